//--- dv/t2cmp_checker.sv
// Concurrent checks on the compare timer ports
`timescale 1ns/100ps
`default_nettype none
`include "t2cmp_regs.svh"

module t2cmp_checker
(
    // Clock and reset
    input wire logic        sys_clk_in,
    input wire logic        rst_n_in,
    // Bus
    input wire logic        hsel_in,
    input wire logic [7:0]  haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic        hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        hreadyout_out,
    input wire logic        hresp_out,
    // Pins
    input wire logic        osc_pin_2_out,
    input wire logic        compare_output_pin_out,
    input wire logic        irq_out
);
    logic       ap;
    logic       rd_ap;
    logic       dp_wr_q;
    logic [7:0] dp_adr_q;
    logic [1:0] mask_q;
    logic [2:0] cs_q;

    // Address phase decode
    assign ap    = hsel_in & hready_in & htrans_in[1];
    assign rd_ap = ap & ~hwrite_in;

    // Pending write data phase
    always_ff @(posedge sys_clk_in)
    begin
        dp_wr_q  <= rst_n_in & ap & hwrite_in;
        dp_adr_q <= haddr_in;
    end

    // Mirror of mask and clock select; needed to know when nothing may change
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            mask_q <= 2'h0;
            cs_q   <= 3'h0;
        end
        else if (dp_wr_q && dp_adr_q == `T2CMP_MASK_OFS)
            mask_q <= hwdata_in[1:0];
        else if (dp_wr_q && dp_adr_q == `T2CMP_CTRL_OFS)
            cs_q <= hwdata_in[2:0];
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    ////////////////////////////////////////////////////////////
    chk_reset_quiet: assert property ($rose(rst_n_in) |->
        hrdata_out == 32'h0 && !irq_out && !compare_output_pin_out) else $error("outputs not quiet after reset");
    chk_bus_const: assert property (hreadyout_out && !hresp_out && !osc_pin_2_out)
        else $error("constant outputs changed");
    chk_byte_width: assert property (rd_ap && haddr_in inside {`T2CMP_COUNT_OFS, `T2CMP_COMPARE_OFS} |=>
        hrdata_out[31:8] == 24'h0) else $error("upper read bits set");
    chk_irq_masked: assert property (mask_q == 2'h0 |-> !irq_out) else $error("irq while masked");
    chk_read_clear: assert property (rd_ap && haddr_in == `T2CMP_FLAG_OFS && cs_q == 3'h0 && !dp_wr_q
        |=> !irq_out) else $error("flag read did not clear");
    chk_wr1_clear: assert property (dp_wr_q && dp_adr_q == `T2CMP_FLAG_OFS && hwdata_in[1:0] == 2'h3
        && cs_q == 3'h0 |=> !irq_out) else $error("write one did not clear");
    chk_stop_still: assert property (cs_q == 3'h0 && !ap && !dp_wr_q |=> $stable(irq_out))
        else $error("event while stopped");
    chk_rdata_hold: assert property (!rd_ap |=> $stable(hrdata_out)) else $error("read data moved");
endmodule : t2cmp_checker

bind t2cmp_top t2cmp_checker u_t2cmp_checker
(
    .sys_clk_in, .rst_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hwdata_in, .hready_in,
    .hrdata_out, .hreadyout_out, .hresp_out, .osc_pin_2_out, .compare_output_pin_out, .irq_out
);
`default_nettype wire

//--- dv/tb_t2cmp_top.sv
// Self-checking bench for the compare timer
`timescale 1ns/100ps
`default_nettype none
`include "t2cmp_regs.svh"

module tb_t2cmp_top;
    logic        clk    = 1'b0;
    logic        rst_n  = 1'b0;
    logic        hsel   = 1'b0;
    logic [7:0]  haddr  = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        osc    = 1'b0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic        hrdy;
    logic        hresp;
    logic        pin;
    logic        irq;
    int          err_count   = 0;
    int          comparisons = 0;
    int          n;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    t2cmp_top u_t2cmp_top
    (
        .sys_clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
        .hreadyout_out(hrdy), .hresp_out(hresp), .osc_pin_1_in(osc), .osc_pin_2_out(),
        .compare_output_pin_out(pin), .irq_out(irq)
    );

    ////////////////////////////////////////////////////////////
    task automatic end_sim;
    begin
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    end
    endtask : chk

    // Bounded wait for hready at the next edges
    task automatic wait_rdy;
        int k;
    begin
        k = 0;
        @(posedge clk);
        while (hrdy !== 1'b1)
        begin
            k++;
            if (k > 100)
            begin
                err_count++;
                end_sim();
            end
            @(posedge clk);
        end
    end
    endtask : wait_rdy

    // One single transfer; read data lands in rd
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    end
    endtask : xfer

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    begin
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rd);
    end
    endtask : rdchk

    // Compare, count, mask, then control last so counting starts clean
    task automatic setup(input logic [7:0] c, input logic [7:0] v, input logic [1:0] m, input logic [7:0] ctl);
    begin
        xfer(1'b1, `T2CMP_COMPARE_OFS, {24'h0, c});
        xfer(1'b1, `T2CMP_COUNT_OFS, {24'h0, v});
        xfer(1'b1, `T2CMP_MASK_OFS, {30'h0, m});
        xfer(1'b1, `T2CMP_CTRL_OFS, {24'h0, ctl});
    end
    endtask : setup

    task automatic wait_irq(input int lim);
    begin
        n = 0;
        while (irq !== 1'b1 && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        chk("irq raised", 32'h1, {31'h0, irq});
        if (irq !== 1'b1)
            end_sim();
    end
    endtask : wait_irq

    ////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 8; i++)
            rdchk("reset read", 8'(i * 4), 32'h0);
        xfer(1'b1, `T2CMP_COMPARE_OFS, 32'hffff_ffa5);
        xfer(1'b1, `T2CMP_COUNT_OFS, 32'hffff_ff3c);
        repeat (10) @(posedge clk);
        rdchk("compare width", `T2CMP_COMPARE_OFS, 32'ha5);
        rdchk("stopped count", `T2CMP_COUNT_OFS, 32'h3c);
        // Match raises irq; a flag read clears it
        setup(8'h10, 8'h00, 2'h1, 8'h01);
        wait_irq(64);
        xfer(1'b1, `T2CMP_CTRL_OFS, 32'h0);
        rdchk("match flag", `T2CMP_FLAG_OFS, 32'h1);
        chk("irq after read", 32'h0, {31'h0, irq});
        // Masked flag stays quiet until unmasked, then write one clears
        setup(8'h10, 8'h00, 2'h0, 8'h01);
        repeat (40) @(posedge clk);
        chk("masked irq", 32'h0, {31'h0, irq});
        xfer(1'b1, `T2CMP_CTRL_OFS, 32'h0);
        xfer(1'b1, `T2CMP_MASK_OFS, 32'h1);
        @(posedge clk);
        chk("unmasked irq", 32'h1, {31'h0, irq});
        xfer(1'b1, `T2CMP_FLAG_OFS, 32'h3);
        @(posedge clk);
        chk("write one clear", 32'h0, {31'h0, irq});
        // Overflow at MAX, then count wraps to BOTTOM
        setup(8'h80, 8'hfd, 2'h2, 8'h01);
        wait_irq(16);
        xfer(1'b1, `T2CMP_CTRL_OFS, 32'h0);
        rdchk("overflow flag", `T2CMP_FLAG_OFS, 32'h2);
        xfer(1'b0, `T2CMP_COUNT_OFS, 32'h0);
        chk("wrapped", 32'h0, {28'h0, rd[7:4]});
        // Compare value as TOP: never reaches MAX
        setup(8'h05, 8'h00, 2'h2, 8'h11);
        repeat (300) @(posedge clk);
        chk("no overflow", 32'h0, {31'h0, irq});
        xfer(1'b1, `T2CMP_CTRL_OFS, 32'h0);
        xfer(1'b0, `T2CMP_COUNT_OFS, 32'h0);
        chk("below top", 32'h0, {31'h0, rd > 32'h5});
        rdchk("top flags", `T2CMP_FLAG_OFS, 32'h1);
        // Oscillator source: only pin edges count
        xfer(1'b1, `T2CMP_ASYNC_OFS, 32'h1);
        setup(8'h03, 8'h00, 2'h1, 8'h01);
        repeat (20) @(posedge clk);
        rdchk("osc idle", `T2CMP_COUNT_OFS, 32'h0);
        repeat (5)
        begin
            osc <= 1'b1;
            repeat (4) @(posedge clk);
            osc <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (6) @(posedge clk);
        rdchk("osc edges", `T2CMP_COUNT_OFS, 32'h5);
        rdchk("osc match", `T2CMP_FLAG_OFS, 32'h1);
        // Stop first, or the io clock runs the count away before the new setup
        xfer(1'b1, `T2CMP_CTRL_OFS, 32'h0);
        xfer(1'b1, `T2CMP_ASYNC_OFS, 32'h0);
        // Toggle on match, then fast PWM at half duty
        setup(8'h02, 8'h00, 2'h0, 8'h21);
        n = 0;
        while (pin !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        chk("pin toggled", 32'h1, {31'h0, pin});
        if (pin !== 1'b1)
            end_sim();
        // PWM period must start from BOTTOM, so stop before reloading
        xfer(1'b1, `T2CMP_CTRL_OFS, 32'h0);
        setup(8'h80, 8'h00, 2'h0, 8'h59);
        n = 0;
        repeat (512)
        begin
            @(posedge clk);
            n += int'(pin);
        end
        chk("pwm duty", 32'h1, {31'h0, n > 248 && n < 264});
        // Phase correct: up to MAX, then down; seven ticks from 0xfe
        xfer(1'b1, `T2CMP_CTRL_OFS, 32'h0);
        setup(8'h40, 8'hfe, 2'h0, 8'h09);
        repeat (5) @(posedge clk);
        xfer(1'b1, `T2CMP_CTRL_OFS, 32'h0);
        rdchk("turn at max", `T2CMP_COUNT_OFS, 32'hf9);
        // Divide by eight: eight ticks in the 66 clocks before the stop lands
        setup(8'h40, 8'h00, 2'h0, 8'h02);
        repeat (64) @(posedge clk);
        xfer(1'b1, `T2CMP_CTRL_OFS, 32'h0);
        rdchk("prescaled count", `T2CMP_COUNT_OFS, 32'h8);
        end_sim();
    end
endmodule : tb_t2cmp_top
`default_nettype wire

//--- rtl/t2cmp_pkg.sv
// Types shared by the 8-bit compare timer files
package t2cmp_pkg;

    // Counting mode
    typedef enum logic [1:0] {
        T2CMP_NORMAL,
        T2CMP_PWM_PC,
        T2CMP_CTC,
        T2CMP_FAST_PWM
    } t2cmp_mode_t;

    // Clock source select
    typedef enum logic [2:0] {
        T2CMP_CS_STOP,
        T2CMP_CS_DIV1,
        T2CMP_CS_DIV8,
        T2CMP_CS_DIV32,
        T2CMP_CS_DIV64,
        T2CMP_CS_DIV128,
        T2CMP_CS_DIV256,
        T2CMP_CS_DIV1024
    } t2cmp_cs_t;

    // Counter status handed to the waveform unit
    typedef struct packed {
        logic tick;
        logic match;
        logic at_top;
        logic at_bottom;
        logic down;
    } t2cmp_cnt_t;

endpackage : t2cmp_pkg

//--- rtl/t2cmp_regs.svh
// Register offsets, field positions and reset values of the 8-bit compare timer
`ifndef T2CMP_REGS_SVH
`define T2CMP_REGS_SVH

// Byte addresses on the register bus
`define T2CMP_COUNT_OFS      8'h00
`define T2CMP_COMPARE_OFS    8'h04
`define T2CMP_CTRL_OFS       8'h08
`define T2CMP_FLAG_OFS       8'h0c
`define T2CMP_MASK_OFS       8'h10
`define T2CMP_ASYNC_OFS      8'h14

// Control register fields
`define T2CMP_CTRL_CS_LSB    0
`define T2CMP_CTRL_CS_MSB    2
`define T2CMP_CTRL_MODE_LSB  3
`define T2CMP_CTRL_MODE_MSB  4
`define T2CMP_CTRL_COM_LSB   5
`define T2CMP_CTRL_COM_MSB   6

// Flag and mask fields
`define T2CMP_FLAG_CMP_BIT   0
`define T2CMP_FLAG_OVF_BIT   1

// Async status fields
`define T2CMP_ASYNC_SEL_BIT  0

// Count sequence limits
`define T2CMP_BOTTOM         8'h00
`define T2CMP_MAX            8'hff
`define T2CMP_RESET_BYTE     8'h00

`endif

//--- rtl/t2cmp_top.sv
// Top of the 8-bit compare timer with its AHB-Lite register slave
// Overview of operation
// - Counter and compare registers are both eight bits wide.
// - Each timer interrupt has a flag and its own mask bit.
// - No clock source selected means the counter holds still.
// - Buffered compare value is compared with the counter on every tick.
// - Compare result drives a PWM or variable frequency waveform pin.
// - Match sets the compare flag; unmasked flag raises the interrupt.
// - Counter value zero is BOTTOM.
// - Counter value all ones is MAX.
// - TOP is MAX or the compare value, depending on mode.
// - Timer clock from io clock, or oscillator pins when async selected.
`timescale 1ns/100ps
`default_nettype none
`include "t2cmp_regs.svh"

module t2cmp_top
(
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [7:0]  haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic [31:0]      hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // Oscillator pins
    input  wire logic        osc_pin_1_in,
    output logic             osc_pin_2_out,
    // Compare output and interrupt
    output logic             compare_output_pin_out,
    output logic             irq_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0]  timer2_count_q;
    logic [7:0]  timer2_compare_q;       // Buffer written by software
    logic [7:0]  compare_active_q;       // Value actually compared
    logic [2:0]  cs_q;
    logic [1:0]  mode_q;
    logic [1:0]  com_q;
    logic [1:0]  flag_q;
    logic [1:0]  mask_q;
    logic        async_clock_select_q;
    logic        down_q;
    logic [9:0]  presc_q;
    logic [2:0]  osc_sync_q;

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite address phase capture
    logic        ph_valid_q;
    logic        ph_write_q;
    logic [7:0]  ph_addr_q;
    logic        addr_take;

    assign addr_take = hsel_in && hready_in && htrans_in[1];

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            ph_valid_q <= 1'b0;
            ph_write_q <= 1'b0;
            ph_addr_q  <= 8'h00;
        end
        else if (hready_in)
        begin
            ph_valid_q <= addr_take;
            ph_write_q <= hwrite_in;
            ph_addr_q  <= haddr_in;
        end
    end

    // Zero wait states; all responses OKAY
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    logic wr_en;
    logic rd_en;

    assign wr_en = ph_valid_q && ph_write_q;
    assign rd_en = addr_take && !hwrite_in;

    // Address match helper used for every register
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////
    // Clock source selection and timer tick
    // Oscillator pin is a foreign domain, so two flops precede the edge detect
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            osc_sync_q <= 3'b000;
        else
            osc_sync_q <= {osc_sync_q[1:0], osc_pin_1_in};
    end

    logic osc_rise;
    assign osc_rise = osc_sync_q[1] && !osc_sync_q[2];
    // Crystal return pin held low; the oscillator model lives outside
    assign osc_pin_2_out = 1'b0;

    // Prescaler source is io clock or the synchronised oscillator edge
    logic src_pulse;
    assign src_pulse = async_clock_select_q ? osc_rise : 1'b1;

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in || cs_q == 3'd0)
            presc_q <= 10'h000;
        else if (src_pulse)
            presc_q <= presc_q + 10'h001;
    end

    // Tap of the prescaler for a divide ratio
    function automatic logic tap(input logic [9:0] p, input logic [9:0] lim);
        tap = ((p & lim) == lim);
    endfunction : tap

    logic tick;
    always_comb
    begin
        tick = 1'b0;
        unique case (t2cmp_pkg::t2cmp_cs_t'(cs_q))
            t2cmp_pkg::T2CMP_CS_STOP:    tick = 1'b0;
            t2cmp_pkg::T2CMP_CS_DIV1:    tick = src_pulse;
            t2cmp_pkg::T2CMP_CS_DIV8:    tick = src_pulse && tap(presc_q, 10'h007);
            t2cmp_pkg::T2CMP_CS_DIV32:   tick = src_pulse && tap(presc_q, 10'h01f);
            t2cmp_pkg::T2CMP_CS_DIV64:   tick = src_pulse && tap(presc_q, 10'h03f);
            t2cmp_pkg::T2CMP_CS_DIV128:  tick = src_pulse && tap(presc_q, 10'h07f);
            t2cmp_pkg::T2CMP_CS_DIV256:  tick = src_pulse && tap(presc_q, 10'h0ff);
            t2cmp_pkg::T2CMP_CS_DIV1024: tick = src_pulse && tap(presc_q, 10'h3ff);
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Count sequence conditions
    logic [7:0] top_val;
    logic       at_top;
    logic       at_bottom;
    logic       at_max;
    logic       match;

    assign at_bottom = (timer2_count_q == `T2CMP_BOTTOM);
    assign at_max    = (timer2_count_q == `T2CMP_MAX);
    // CTC uses the compare value as TOP, others run to MAX
    assign top_val   = (mode_q == 2'd2) ? compare_active_q : `T2CMP_MAX;
    assign at_top    = (timer2_count_q == top_val);
    assign match     = (timer2_count_q == compare_active_q);

    ////////////////////////////////////////////////////////////////////////////
    // Counter; a software write wins over a tick
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            timer2_count_q <= `T2CMP_RESET_BYTE;
            down_q         <= 1'b0;
        end
        else if (wr_en && hit(ph_addr_q, `T2CMP_COUNT_OFS))
            timer2_count_q <= hwdata_in[7:0];
        else if (tick)
        begin
            if (mode_q == 2'd1)
            begin
                // Phase correct: up to MAX, down to BOTTOM
                if (!down_q && at_max)
                begin
                    down_q         <= 1'b1;
                    timer2_count_q <= timer2_count_q - 8'h01;
                end
                else if (down_q && at_bottom)
                begin
                    down_q         <= 1'b0;
                    timer2_count_q <= timer2_count_q + 8'h01;
                end
                else
                    timer2_count_q <= down_q ? timer2_count_q - 8'h01 : timer2_count_q + 8'h01;
            end
            else
            begin
                down_q <= 1'b0;
                timer2_count_q <= at_top ? `T2CMP_BOTTOM : timer2_count_q + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare double buffer; PWM modes update at TOP to avoid glitches
    logic pwm_mode;
    assign pwm_mode = mode_q[0];

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            compare_active_q <= `T2CMP_RESET_BYTE;
        else if (!pwm_mode || (tick && at_top))
            compare_active_q <= timer2_compare_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            timer2_compare_q     <= `T2CMP_RESET_BYTE;
            cs_q                 <= 3'd0;
            mode_q               <= 2'd0;
            com_q                <= 2'd0;
            mask_q               <= 2'b00;
            async_clock_select_q <= 1'b0;
        end
        else if (wr_en)
        begin
            if (hit(ph_addr_q, `T2CMP_COMPARE_OFS))
                timer2_compare_q <= hwdata_in[7:0];
            if (hit(ph_addr_q, `T2CMP_CTRL_OFS))
            begin
                cs_q   <= hwdata_in[`T2CMP_CTRL_CS_MSB:`T2CMP_CTRL_CS_LSB];
                mode_q <= hwdata_in[`T2CMP_CTRL_MODE_MSB:`T2CMP_CTRL_MODE_LSB];
                com_q  <= hwdata_in[`T2CMP_CTRL_COM_MSB:`T2CMP_CTRL_COM_LSB];
            end
            if (hit(ph_addr_q, `T2CMP_MASK_OFS))
                mask_q <= hwdata_in[1:0];
            if (hit(ph_addr_q, `T2CMP_ASYNC_OFS))
                async_clock_select_q <= hwdata_in[`T2CMP_ASYNC_SEL_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags; setting beats clearing in the same cycle
    logic [1:0] flag_set;
    logic [1:0] flag_clr;

    assign flag_set[`T2CMP_FLAG_CMP_BIT] = tick && match;
    assign flag_set[`T2CMP_FLAG_OVF_BIT] = tick && at_max && (mode_q != 2'd2);
    // Cleared by a read of the flag register or by writing one
    assign flag_clr = ((rd_en && hit(haddr_in, `T2CMP_FLAG_OFS)) ? 2'b11 : 2'b00) |
                      ((wr_en && hit(ph_addr_q, `T2CMP_FLAG_OFS)) ? hwdata_in[1:0] : 2'b00);

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            flag_q <= 2'b00;
        else
            flag_q <= (flag_q & ~flag_clr) | flag_set;
    end

    assign irq_out = |(flag_q & mask_q);

    ////////////////////////////////////////////////////////////////////////////
    // Read data, registered in the address phase
    logic [31:0] rdata_q;

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            rdata_q <= 32'h0000_0000;
        else if (rd_en)
        begin
            unique case (haddr_in)
                `T2CMP_COUNT_OFS:   rdata_q <= {24'h000000, timer2_count_q};
                `T2CMP_COMPARE_OFS: rdata_q <= {24'h000000, timer2_compare_q};
                `T2CMP_CTRL_OFS:    rdata_q <= {25'h0000000, com_q, mode_q, cs_q};
                `T2CMP_FLAG_OFS:    rdata_q <= {30'h00000000, flag_q};
                `T2CMP_MASK_OFS:    rdata_q <= {30'h00000000, mask_q};
                `T2CMP_ASYNC_OFS:   rdata_q <= {31'h00000000, async_clock_select_q};
                default:            rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign hrdata_out = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Waveform generator
    t2cmp_pkg::t2cmp_cnt_t cnt_s;
    assign cnt_s = '{tick: tick, match: match, at_top: at_top, at_bottom: at_bottom, down: down_q};

    t2cmp_wave u_wave
    (
        .sys_clk_in             (sys_clk_in),
        .rst_n_in               (rst_n_in),
        .cnt_in                 (cnt_s),
        .mode_in                (t2cmp_pkg::t2cmp_mode_t'(mode_q)),
        .com_in                 (com_q),
        .compare_output_pin_out (compare_output_pin_out)
    );

endmodule : t2cmp_top

`default_nettype wire

//--- rtl/t2cmp_wave.sv
// Waveform generator driving the compare output pin
`timescale 1ns/100ps
`default_nettype none
`include "t2cmp_regs.svh"

module t2cmp_wave
(
    // Clock and reset
    input  wire logic                sys_clk_in,
    input  wire logic                rst_n_in,
    // Counter status
    input  wire t2cmp_pkg::t2cmp_cnt_t cnt_in,
    input  wire t2cmp_pkg::t2cmp_mode_t mode_in,
    input  wire logic [1:0]          com_in,
    // Pin
    output logic                     compare_output_pin_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Output level; only changes on a timer tick
    logic wave_q;

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            wave_q <= 1'b0;
        else if (cnt_in.tick && com_in != 2'b00)
        begin
            unique case (mode_in)
                t2cmp_pkg::T2CMP_NORMAL, t2cmp_pkg::T2CMP_CTC:
                begin
                    // Variable frequency: toggle, clear or set on match
                    if (cnt_in.match)
                        wave_q <= (com_in == 2'b01) ? ~wave_q : com_in[0];
                end
                t2cmp_pkg::T2CMP_FAST_PWM:
                begin
                    // Match ends the pulse, BOTTOM starts the next one
                    if (cnt_in.match)
                        wave_q <= com_in[0];
                    else if (cnt_in.at_bottom)
                        wave_q <= ~com_in[0];
                end
                t2cmp_pkg::T2CMP_PWM_PC:
                begin
                    // Direction decides the level at match
                    if (cnt_in.match)
                        wave_q <= cnt_in.down ? ~com_in[0] : com_in[0];
                end
            endcase
        end
    end

    assign compare_output_pin_out = wave_q;

endmodule : t2cmp_wave

`default_nettype wire
